// File: ccum_pkg.sv
/*
  ccum_pkg: shared constants and carriers for the upper register map
  and the reset behaviour of the core control registers.
  Assumes a 7-bit decoded map (the address msb is never decoded) and
  byte-wide host data.
*/
package ccum_pkg;

  // decoded address width and internal ram size
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned RAM_BYTES = 80;
  localparam int unsigned RAM_AW = 7;

  // low-map control registers
  localparam logic [6:0] ADDR_MODE = 7'h00;
  localparam logic [6:0] ADDR_CMD = 7'h01;
  localparam logic [6:0] ADDR_STAT = 7'h02;
  localparam logic [6:0] ADDR_IRQ = 7'h03;

  // upper map
  localparam logic [6:0] ADDR_PEEK0 = 7'h1b;
  localparam logic [6:0] ADDR_PEEK1 = 7'h1c;
  localparam logic [6:0] ADDR_RX_CNT = 7'h1d;
  localparam logic [6:0] ADDR_RBSA = 7'h1e;
  localparam logic [6:0] ADDR_CDR = 7'h1f;
  localparam logic [6:0] ADDR_RAM_LO = 7'h20;
  localparam logic [6:0] ADDR_RAM_HI = 7'h6f;
  localparam logic [6:0] ADDR_ZERO_LO = 7'h70;

  // receive fifo window and the byte that follows a standard message
  localparam logic [5:0] PEEK_OFS = 6'h0b;

  // values after a hardware reset
  localparam logic [7:0] MODE_HW = 8'h01;
  localparam logic [7:0] STAT_HW = 8'h3c;
  localparam logic [7:0] IRQ_HW = 8'h00;
  localparam logic [7:0] RBSA_HW = 8'h00;
  localparam logic [7:0] CDR_HW = 8'h00;

  // interrupt bit that survives entry into reset mode
  localparam int unsigned IRQ_EW_BIT = 2;
  localparam logic [7:0] IRQ_KEEP_MASK = 8'h04;

  // clock divider bits that change only in reset mode
  localparam logic [7:0] CDR_LOCK_MASK = 8'he8;

  // mode register layout
  typedef struct packed {
    logic [2:0] rsv;
    logic sleep_bit;
    logic filter_select_bit;
    logic self_test_bit;
    logic listen_only_bit;
    logic reset_mode_bit;
  } ccum_mode_s;

  // status register layout
  typedef struct packed {
    logic bus_off_flag;
    logic error_flag;
    logic transmit_status;
    logic receive_status;
    logic transmission_complete_flag;
    logic transmit_buffer_released_flag;
    logic overrun_flag;
    logic receive_buffer_full_flag;
  } ccum_stat_s;

  // command strobe layout
  typedef struct packed {
    logic [2:0] rsv;
    logic self_reception_request;
    logic clear_overrun_cmd;
    logic release_receive_buffer_cmd;
    logic abort_transmission_cmd;
    logic transmit_request_cmd;
  } ccum_cmd_s;

endpackage : ccum_pkg

// File: ccum_ram.sv
/*
  ccum_ram: the 80-byte internal ram (receive fifo, transmit buffer,
  free bytes) with one write port and two combinational read ports.
  Assumes the owner arbitrates the single write port.
*/
`timescale 1ns/1ns
module ccum_ram import ccum_pkg::*; (
  // clock
  input wire logic i_ref_clk,
  // write port
  input wire logic i_we,
  input wire logic [RAM_AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // read ports
  input wire logic [RAM_AW-1:0] i_raddr_a,
  output logic [7:0] o_rdata_a,
  input wire logic [RAM_AW-1:0] i_raddr_b,
  output logic [7:0] o_rdata_b
);

  // storage, contents undefined after power-up
  logic [7:0] mem [RAM_BYTES];

  // byte write
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // reads; an address past the ram size returns x, which callers leave unused
  assign o_rdata_a = mem[i_raddr_a];
  assign o_rdata_b = mem[i_raddr_b];

endmodule : ccum_ram

// File: ccum_regs.sv
/*
  ccum_regs: upper register map (27..127, aliased above 128) and the
  control registers whose reset behaviour is defined here: mode,
  command, status and interrupt flags.
  Assumes a byte-wide host port synchronous to i_ref_clk and a protocol
  engine that drives the status, interrupt and ram engine inputs.
*/
// Notes on behaviour
// - address msb ignored, upper half aliases low
// - 32..111 map ram, writable in reset only
// - 27/28 peek fifo bytes after current message, read zero in reset mode
// - start pointer writable only in reset mode
// - locked divider bits change only in reset
// - setting reset bit aborts traffic, enters reset
// - clearing reset bit resumes the selected mode
// - mode reset values for hardware and entry
// - command bits always read zero after resets
// - status reset values, some kept on entry
// - interrupt flags cleared, warning kept on entry
// - separate decoding for operating and reset mode
`timescale 1ns/1ns
module ccum_regs import ccum_pkg::*; (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // host register port
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // protocol engine events and state
  input wire logic i_bus_off,
  input wire logic i_stat_wr,
  input wire ccum_stat_s i_stat,
  input wire logic [7:0] i_irq_set,
  input wire logic [7:0] i_rx_msg_count,
  // protocol engine ram port
  input wire logic i_eng_we,
  input wire logic [RAM_AW-1:0] i_eng_addr,
  input wire logic [7:0] i_eng_wdata,
  output logic [7:0] o_eng_rdata,
  // control outputs
  output ccum_mode_s o_mode,
  output ccum_cmd_s o_cmd,
  output logic [7:0] o_cdr,
  output logic [7:0] o_rbsa,
  output logic o_abort,
  output logic o_resume
);

  // registers
  ccum_mode_s mode_r, mode_nxt; // mode register
  ccum_stat_s stat_r, stat_nxt; // status register
  logic [7:0] irq_r, irq_nxt; // interrupt flags
  logic [7:0] rbsa_r, rbsa_nxt; // receive buffer start pointer
  logic [7:0] cdr_r, cdr_nxt; // clock divider
  ccum_cmd_s cmd_r, cmd_nxt; // one-cycle command strobes
  logic [7:0] rdata_r, rdata_nxt; // host read data
  logic abort_r, resume_r; // mode change pulses

  // address decode on the low seven bits only
  logic [6:0] a7;
  assign a7 = i_addr[6:0];

  logic rm;
  assign rm = mode_r.reset_mode_bit;

  // select lines
  logic sel_mode, sel_cmd, sel_stat, sel_irq;
  logic sel_peek0, sel_peek1, sel_cnt, sel_rbsa, sel_cdr;
  logic sel_ram, sel_zero;
  assign sel_mode = (a7 == ADDR_MODE);
  assign sel_cmd = (a7 == ADDR_CMD);
  assign sel_stat = (a7 == ADDR_STAT);
  assign sel_irq = (a7 == ADDR_IRQ);
  assign sel_peek0 = (a7 == ADDR_PEEK0);
  assign sel_peek1 = (a7 == ADDR_PEEK1);
  assign sel_cnt = (a7 == ADDR_RX_CNT);
  assign sel_rbsa = (a7 == ADDR_RBSA);
  assign sel_cdr = (a7 == ADDR_CDR);
  assign sel_ram = (a7 >= ADDR_RAM_LO) && (a7 <= ADDR_RAM_HI);
  assign sel_zero = (a7 >= ADDR_ZERO_LO);

  // write enables; start pointer and ram writes gated by reset mode
  logic wr_mode, wr_cmd, wr_rbsa, wr_cdr, wr_ram;
  assign wr_mode = i_wr && sel_mode;
  assign wr_cmd = i_wr && sel_cmd;
  assign wr_rbsa = i_wr && sel_rbsa && rm;
  assign wr_cdr = i_wr && sel_cdr;
  assign wr_ram = i_wr && sel_ram && rm;

  // ram addressing: host window, then fifo peek bytes
  logic [RAM_AW-1:0] host_ram_addr;
  logic [5:0] peek_idx;
  logic [RAM_AW-1:0] host_raddr;
  logic [7:0] ram_rdata;
  assign host_ram_addr = a7 - ADDR_RAM_LO;
  // fifo index wraps at 64 bytes behind the current message
  assign peek_idx = rbsa_r[5:0] + PEEK_OFS + {5'h00, sel_peek1};
  assign host_raddr = (sel_peek0 || sel_peek1) ? {1'b0, peek_idx} :
                      host_ram_addr;

  // single write port: host in reset mode, engine in operating mode
  logic ram_we;
  logic [RAM_AW-1:0] ram_waddr;
  logic [7:0] ram_wdata;
  assign ram_we = wr_ram || (i_eng_we && !rm);
  assign ram_waddr = wr_ram ? host_ram_addr : i_eng_addr;
  assign ram_wdata = wr_ram ? i_wdata : i_eng_wdata;

  ccum_ram u_ram (
    .i_ref_clk (i_ref_clk),
    .i_we (ram_we),
    .i_waddr (ram_waddr),
    .i_wdata (ram_wdata),
    .i_raddr_a (host_raddr),
    .o_rdata_a (ram_rdata),
    .i_raddr_b (i_eng_addr),
    .o_rdata_b (o_eng_rdata)
  );

  // reset mode entry and exit
  logic enter_rm, leave_rm;
  assign enter_rm = mode_nxt.reset_mode_bit && !rm;
  assign leave_rm = !mode_nxt.reset_mode_bit && rm;

  // mode register next value
  always_comb begin
    mode_nxt = mode_r;
    if (wr_mode) begin
      if (rm) begin
        // reset mode decoding: every mode field is writable
        mode_nxt = ccum_mode_s'(i_wdata);
      end else begin
        // operating mode: only sleep and reset bits move
        mode_nxt.sleep_bit = i_wdata[4];
        mode_nxt.reset_mode_bit = i_wdata[0];
      end
      mode_nxt.rsv = 3'h0;
    end
    if (i_bus_off) begin
      // bus-off forces reset mode
      mode_nxt.reset_mode_bit = 1'b1;
    end
    if (mode_nxt.reset_mode_bit && !rm) begin
      // entry keeps filter, self-test and listen-only
      mode_nxt.sleep_bit = 1'b0;
      mode_nxt.rsv = 3'h0;
    end
  end

  // command strobes last one cycle and never read back
  assign cmd_nxt = (wr_cmd && !enter_rm) ?
                   ccum_cmd_s'({3'h0, i_wdata[4:0]}) : '0;

  // status register next value
  always_comb begin
    stat_nxt = stat_r;
    if (i_stat_wr && !rm) begin
      stat_nxt = i_stat;
    end
    if (enter_rm) begin
      // bus-off, error and complete are kept on entry
      stat_nxt.transmit_status = 1'b1;
      stat_nxt.receive_status = 1'b1;
      stat_nxt.transmit_buffer_released_flag = 1'b1;
      stat_nxt.overrun_flag = 1'b0;
      stat_nxt.receive_buffer_full_flag = 1'b0;
    end
  end

  // interrupt flags: read clears, a new event wins over the clear
  logic irq_rd;
  assign irq_rd = i_rd && sel_irq;
  always_comb begin
    irq_nxt = irq_r;
    if (irq_rd) begin
      irq_nxt = 8'h00;
    end
    irq_nxt = irq_nxt | i_irq_set;
    if (enter_rm) begin
      // only the error warning flag survives entry
      irq_nxt = irq_nxt & IRQ_KEEP_MASK;
    end
  end

  // pointer and divider next values
  assign rbsa_nxt = wr_rbsa ? i_wdata : rbsa_r;
  // locked divider bits keep their value outside reset mode
  assign cdr_nxt = !wr_cdr ? cdr_r :
                   rm ? i_wdata :
                   ((cdr_r & CDR_LOCK_MASK) |
                    (i_wdata & ~CDR_LOCK_MASK));

  // read multiplexer; reset mode decodes 27/28 as zero
  logic [7:0] peek_data;
  assign peek_data = rm ? 8'h00 : ram_rdata;
  always_comb begin
    rdata_nxt = rdata_r;
    if (i_rd) begin
      rdata_nxt = 8'h00;
      if (sel_mode) begin
        rdata_nxt = mode_r;
      end else if (sel_stat) begin
        rdata_nxt = stat_r;
      end else if (sel_irq) begin
        rdata_nxt = irq_r;
      end else if (sel_peek0 || sel_peek1) begin
        rdata_nxt = peek_data;
      end else if (sel_cnt) begin
        rdata_nxt = i_rx_msg_count;
      end else if (sel_rbsa) begin
        rdata_nxt = rbsa_r;
      end else if (sel_cdr) begin
        rdata_nxt = cdr_r;
      end else if (sel_ram) begin
        rdata_nxt = ram_rdata;
      end
    end
  end

  // control registers with their hardware reset values
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mode_r <= ccum_mode_s'(MODE_HW);
      stat_r <= ccum_stat_s'(STAT_HW);
      irq_r <= IRQ_HW;
      cmd_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      stat_r <= stat_nxt;
      irq_r <= irq_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  // configuration and read data
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rbsa_r <= RBSA_HW;
      cdr_r <= CDR_HW;
      rdata_r <= 8'h00;
    end else begin
      rbsa_r <= rbsa_nxt;
      cdr_r <= cdr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // mode change pulses toward the protocol engine
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      abort_r <= 1'b0;
      resume_r <= 1'b0;
    end else begin
      abort_r <= enter_rm;
      resume_r <= leave_rm;
    end
  end

  // outputs
  assign o_rdata = rdata_r;
  assign o_mode = mode_r;
  assign o_cmd = cmd_r;
  assign o_cdr = cdr_r;
  assign o_rbsa = rbsa_r;
  assign o_abort = abort_r;
  assign o_resume = resume_r;

  // checks on the register behaviour
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_alias_count: assert property (
    i_rd && (i_addr[6:0] == ADDR_RX_CNT) |=>
      o_rdata == $past(i_rx_msg_count))
    else $error("message counter read or alias wrong");

  a_ram_write_gate: assert property (
    i_wr && sel_ram && !rm |-> !wr_ram)
    else $error("ram written by host in operating mode");

  a_peek_read: assert property (
    i_rd && sel_peek0 && !rm |=> o_rdata == $past(ram_rdata))
    else $error("fifo peek returned wrong byte");

  a_rbsa_lock: assert property (
    i_wr && sel_rbsa && !rm |=> $stable(rbsa_r))
    else $error("start pointer changed in operating mode");

  a_cdr_lock: assert property (
    i_wr && sel_cdr && !rm |=>
      (cdr_r & CDR_LOCK_MASK) == ($past(cdr_r) & CDR_LOCK_MASK))
    else $error("locked divider bits changed in operating mode");

  a_entry_abort: assert property (
    $rose(rm) |-> o_abort ##1 !o_abort)
    else $error("reset mode entry without single abort pulse");

  a_exit_resume: assert property (
    $fell(rm) |-> o_resume && !o_mode.reset_mode_bit)
    else $error("reset mode exit without resume pulse");

  a_hw_mode: assert property (
    $past(i_rst) |-> mode_r == ccum_mode_s'(MODE_HW))
    else $error("mode value after hardware reset wrong");

  a_cmd_zero: assert property (
    i_rd && sel_cmd |=> o_rdata == 8'h00)
    else $error("command location read non-zero");

  a_entry_status: assert property (
    $rose(rm) && !$past(i_rst) |->
      stat_r == {$past(stat_r[7:6]), 2'b11, $past(stat_r[3]), 3'b100})
    else $error("status not set up on reset mode entry");

  a_entry_irq: assert property (
    $rose(rm) && !$past(i_rst) |-> (irq_r & ~IRQ_KEEP_MASK) == 8'h00)
    else $error("interrupt flags not cleared on entry");

  a_upper_zero: assert property (
    i_rd && sel_zero |=> o_rdata == 8'h00)
    else $error("upper locations read non-zero");

endmodule : ccum_regs

// File: ccum_host.sv
/*
  ccum_host: host cpu model that makes byte reads and writes on the
  register port of the upper map block.
  Assumes callers enter its task just after a rising clock edge.
*/
`timescale 1ns/1ns
module ccum_host (
  // clock and read data
  input wire logic i_ref_clk,
  input wire logic [7:0] i_rdata,
  // register port towards the block
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  // idle port at time zero
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end

  // one byte access: strobe for one edge, then a quiet edge so that
  // back to back calls never touch a strobe twice in one time step;
  // released lines show the inverse so stale values cannot pass
  // callers never address the production test register
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= ~w;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    @(posedge i_ref_clk);
    q = i_rdata;
  endtask : acc
endmodule : ccum_host

// File: tb.sv
/*
  tb: self-checking bench for the upper map and reset behaviour.
  Assumes the host model drives the register port and the bench plays
  the protocol engine.
*/
`timescale 1ns/1ns
module tb import ccum_pkg::*; ();
  // clock, reset and register port
  logic ref_clk;
  logic rst;
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  // engine side stimulus
  logic bus_off;
  logic stat_wr;
  ccum_stat_s stat;
  logic [7:0] irq_set;
  logic [7:0] rx_cnt;
  logic eng_we;
  logic [6:0] eng_addr;
  logic [7:0] eng_wdata;
  logic [7:0] eng_rdata;
  // control outputs
  ccum_mode_s mode;
  ccum_cmd_s cmd;
  logic [7:0] cdr;
  logic [7:0] rbsa;
  logic abort;
  logic resume;
  // bookkeeping
  int miscompares = 0;
  int num_checks = 0;
  int aborts = 0;
  int resumes = 0;
  logic [7:0] q;

  // block under test
  ccum_regs ccum_regs_i (.i_ref_clk(ref_clk), .i_rst(rst), .i_addr(addr),
    .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
    .i_bus_off(bus_off), .i_stat_wr(stat_wr), .i_stat(stat),
    .i_irq_set(irq_set), .i_rx_msg_count(rx_cnt), .i_eng_we(eng_we),
    .i_eng_addr(eng_addr), .i_eng_wdata(eng_wdata),
    .o_eng_rdata(eng_rdata), .o_mode(mode), .o_cmd(cmd), .o_cdr(cdr),
    .o_rbsa(rbsa), .o_abort(abort), .o_resume(resume));

  // host model on the register port
  ccum_host ccum_host_i (.i_ref_clk(ref_clk), .i_rdata(rdata),
    .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // count abort and resume pulses
  always @(posedge ref_clk) begin
    if (abort === 1'b1) aborts++;
    if (resume === 1'b1) resumes++;
  end

  // verdict and end of run
  task automatic stop_test;
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // pulse count compare
  task automatic chk_n(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_n

  // host write and checked read
  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    ccum_host_i.acc(1'b1, a, d, q);
  endtask : wr_b
  task automatic rd_b(input logic [7:0] a, input logic [7:0] exp);
    ccum_host_i.acc(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rd_b

  // hardware reset held for 10 cycles
  task automatic hw_reset;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
  endtask : hw_reset

  // hardware reset values, including one read through the alias
  task automatic t_reset_vals;
    rd_b(8'h00, 8'h01);
    rd_b(8'h80, 8'h01);
    rd_b(8'h01, 8'h00);
    rd_b(8'h02, 8'h3c);
    rd_b(8'h03, 8'h00);
    rd_b(8'h1e, 8'h00);
  endtask : t_reset_vals

  // reset mode map: alias write, ram, reserved and read-only places
  task automatic t_reset_map;
    wr_b(8'h9e, 8'h55);
    rd_b(8'h1e, 8'h55);
    wr_b(8'h40, 8'ha1);
    wr_b(8'h41, 8'hb2);
    wr_b(8'h20, 8'hc3);
    rd_b(8'h40, 8'ha1);
    rd_b(8'h1b, 8'h00);
    wr_b(8'h70, 8'hff);
    rd_b(8'h70, 8'h00);
    wr_b(8'h1d, 8'hff);
    rd_b(8'h1d, 8'h07);
    wr_b(8'h1f, 8'hff);
    rd_b(8'h1f, 8'hff);
    wr_b(8'h00, 8'h0f);
  endtask : t_reset_map

  // operating mode: locked writes, fifo peek, engine ram port
  task automatic t_operate;
    wr_b(8'h00, 8'h0e);
    chk(mode, 8'h0e);
    rd_b(8'h1b, 8'ha1);
    rd_b(8'h1c, 8'hb2);
    wr_b(8'h1e, 8'h00);
    rd_b(8'h1e, 8'h55);
    chk(rbsa, 8'h55);
    wr_b(8'h40, 8'h00);
    rd_b(8'h40, 8'ha1);
    wr_b(8'h1f, 8'h00);
    rd_b(8'h1f, 8'he8);
    chk(cdr, 8'he8);
    rd_b(8'h9d, 8'h07);
    eng_addr <= 7'h05;
    eng_wdata <= 8'h5a;
    eng_we <= 1'b1;
    @(posedge ref_clk);
    eng_we <= 1'b0;
    eng_addr <= 7'h00;
    @(posedge ref_clk);
    chk(eng_rdata, 8'hc3);
    rd_b(8'h25, 8'h5a);
    wr_b(8'h00, 8'h10);
    rd_b(8'h00, 8'h1e);
  endtask : t_operate

  // entry into reset mode with status and flags set by the engine
  task automatic t_entry;
    stat <= ccum_stat_s'(8'hc3);
    stat_wr <= 1'b1;
    irq_set <= 8'hff;
    @(posedge ref_clk);
    stat_wr <= 1'b0;
    irq_set <= 8'h00;
    @(posedge ref_clk);
    rd_b(8'h02, 8'hc3);
    wr_b(8'h00, 8'h01);
    rd_b(8'h00, 8'h0f);
    rd_b(8'h02, 8'hf4);
    rd_b(8'h03, 8'h04);
    rd_b(8'h01, 8'h00);
    chk_n(aborts, 1);
    chk_n(resumes, 1);
  endtask : t_entry

  // operating mode strobes, read-clear against a new event, bus-off
  task automatic t_bus_off;
    wr_b(8'h00, 8'h02);
    // command strobe stands for exactly one cycle, reserved bits zero
    fork
      wr_b(8'h01, 8'hff);
      begin
        @(posedge ref_clk);
        #1 chk(cmd, 8'h1f);
        @(posedge ref_clk);
        #1 chk(cmd, 8'h00);
      end
    join
    @(posedge ref_clk);
    // a flag set in the clearing read cycle survives the clear
    fork
      rd_b(8'h03, 8'h00);
      begin
        irq_set <= 8'h02;
        @(posedge ref_clk);
        irq_set <= 8'h00;
      end
    join
    rd_b(8'h03, 8'h02);
    // bus-off forces reset mode and drops a command in that cycle
    fork
      wr_b(8'h01, 8'h01);
      begin
        bus_off <= 1'b1;
        @(posedge ref_clk);
        bus_off <= 1'b0;
        #1 chk(cmd, 8'h00);
      end
    join
    chk(mode, 8'h03);
    rd_b(8'h00, 8'h03);
    chk_n(aborts, 2);
    chk_n(resumes, 2);
  endtask : t_bus_off

  // watchdog, far beyond the 130 or so cycles the tests need
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    bus_off = 1'b0;
    stat_wr = 1'b0;
    stat = ccum_stat_s'(8'h00);
    irq_set = 8'h00;
    rx_cnt = 8'h07;
    eng_we = 1'b0;
    eng_addr = 7'h00;
    eng_wdata = 8'h00;
    hw_reset();
    t_reset_vals();
    t_reset_map();
    t_operate();
    t_entry();
    t_bus_off();
    hw_reset();
    t_reset_vals();
    stop_test();
  end
endmodule : tb
